// >>> core/int_code_pkg.sv
package int_code_pkg;

	// Interrupt codes reported to the host.
	localparam logic [7:0] CODE_RESET      = 8'h01;
	localparam logic [7:0] CODE_REG_PARITY = 8'h22;
	localparam logic [7:0] CODE_TIMEOUT    = 8'h2c;
	localparam logic [7:0] CODE_BUS_FREE   = 8'h31;
	localparam logic [7:0] CODE_PHASE_CHG  = 8'h32;
	localparam logic [7:0] CODE_BAD_PHASE  = 8'h54;
	localparam logic [7:0] CODE_UNEXP_MSG  = 8'h55;
	localparam logic [7:0] CODE_UNEXP_STS  = 8'h56;
	localparam logic [7:0] CODE_BUSY_MSG   = 8'h5d;
	localparam logic [7:0] CODE_BUSY_STS   = 8'h5e;
	localparam logic [7:0] CODE_DONE       = 8'h60;
	localparam logic [7:0] CODE_MSG_LONG   = 8'h64;
	localparam logic [7:0] CODE_PAUSE      = 8'h67;
	localparam logic [7:0] CODE_FREE_FIRST = 8'h70;

	// Step codes.
	localparam logic [7:0] STEP_BEFORE     = 8'h00;
	localparam logic [7:0] STEP_DURING     = 8'h01;
	localparam logic [7:0] STEP_DONE_MAN   = 8'h02;
	localparam logic [7:0] STEP_DONE_AUTO  = 8'h0a;

	// Bus phase as {MSG, C/D, I/O}.
	localparam logic [2:0] PHASE_DATA_IN   = 3'b001;
	localparam logic [2:0] PHASE_STATUS    = 3'b011;
	localparam logic [2:0] PHASE_MSG_OUT   = 3'b110;
	localparam logic [2:0] PHASE_MSG_IN    = 3'b111;

	localparam int         MSG_LEN_W       = 8;
	localparam logic [7:0] MSG_LEN_LIMIT   = 8'h21;

	localparam int         ENTRY_W         = 16;
	localparam int         QUEUE_DEPTH     = 4;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_WREQ  = 3'b001,
		ST_XFER  = 3'b010,
		ST_UNEXP = 3'b011,
		ST_EXIT  = 3'b100,
		ST_PUSH  = 3'b101,
		ST_PUSH2 = 3'b110
	} state_type;

endpackage

// >>> core/code_queue.sv
`timescale 1ns/100ps
`default_nettype none

module code_queue #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input  wire logic             sys_clk_i,
	input  wire logic             rst_b_i,
	// Write side.
	input  wire logic             push_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	output logic                  full_o,
	// Read side.
	input  wire logic             pop_i,
	output logic                  empty_o,
	output logic                  rd_valid_o,
	output logic      [WIDTH-1:0] rd_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic             do_push;
	logic             do_pop;

	assign full_o  = (count_q == (AW+1)'(DEPTH));
	assign empty_o = (count_q == '0);
	assign do_push = push_i && !full_o;
	assign do_pop  = pop_i && !empty_o;

	always_ff @(posedge sys_clk_i) begin
		if (do_push) begin
			mem_q[wr_ptr_q] <= wr_data_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_q <= wr_ptr_q + AW'(1);
			end
			if (do_pop) begin
				rd_ptr_q <= rd_ptr_q + AW'(1);
			end
			count_q <= count_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o  <= '0;
		end else begin
			rd_valid_o <= do_pop;
			if (do_pop) begin
				rd_data_o <= mem_q[rd_ptr_q];
			end
		end
	end

endmodule

`default_nettype wire

// >>> core/initiator_int_codes.sv
`timescale 1ns/100ps
`default_nettype none

module initiator_int_codes
	import int_code_pkg::*;
#(
	parameter int QDEPTH = int_code_pkg::QUEUE_DEPTH
) (
	// Clock and reset.
	input  wire logic                              sys_clk_i,
	input  wire logic                              rst_b_i,
	// Command start pulses.
	input  wire logic                              recv_pad_cmd_i,
	input  wire logic                              send_single_message_cmd_i,
	input  wire logic                              send_single_message_attn_cmd_i,
	input  wire logic [int_code_pkg::MSG_LEN_W-1:0] msg_len_i,
	input  wire logic                              count_zero_i,
	// Mode settings.
	input  wire logic                              auto_recv_mode_i,
	input  wire logic                              auto_rst_ack_mode_i,
	input  wire logic                              async_mode_i,
	// Bus events from the transfer engine.
	input  wire logic                              scsi_reset_i,
	input  wire logic                              bus_free_i,
	input  wire logic                              req_timeout_i,
	input  wire logic                              phase_change_i,
	input  wire logic                              pause_accept_i,
	input  wire logic                              first_req_i,
	input  wire logic [2:0]                        req_phase_i,
	input  wire logic                              unexp_byte_rcvd_i,
	input  wire logic                              inbound_control_byte_buffer_full_i,
	input  wire logic                              padding_active_i,
	input  wire logic                              xfer_done_i,
	input  wire logic                              exit_done_i,
	input  wire logic                              reg_parity_err_i,
	// Host side.
	input  wire logic                              code_ack_i,
	output logic      [7:0]                        int_code_o,
	output logic      [7:0]                        int_step_o,
	output logic                                   int_pend_o,
	output logic                                   busy_o,
	// Bus control.
	output logic                                   atn_o,
	output logic                                   pad_from_start_o
);
	import int_code_pkg::*;

	state_type    state_q;
	state_type    state_d;
	logic         is_msg_q;
	logic         keep_atn_q;
	logic         unexp_sts_q;
	logic         padding_q;
	logic [7:0]   code_q;
	logic [7:0]   code_d;
	logic [7:0]   step_q;
	logic [7:0]   step_d;
	logic         par_err_q;
	logic         atn_q;
	logic         pad_start_q;
	logic         int_pend_q;
	logic [7:0]   int_code_q;
	logic [7:0]   int_step_q;
	logic         pop_wait_q;

	logic         q_push;
	logic [15:0]  q_wr_data;
	logic         q_full;
	logic         q_pop;
	logic         q_empty;
	logic         q_rd_valid;
	logic [15:0]  q_rd_data;
	logic         start_any;
	logic         start_msg;
	logic         phase_ok;

	// Step for normal completion; padding suppresses the automatic form.
	function automatic logic [7:0] done_step(input logic auto_ack, input logic padding);
		done_step = (auto_ack && !padding) ? STEP_DONE_AUTO : STEP_DONE_MAN;
	endfunction

	// Code for an unexpected byte, split by phase and buffer occupancy.
	function automatic logic [7:0] unexp_code(input logic is_sts, input logic busy);
		if (busy) begin
			unexp_code = is_sts ? CODE_BUSY_STS : CODE_BUSY_MSG;
		end else begin
			unexp_code = is_sts ? CODE_UNEXP_STS : CODE_UNEXP_MSG;
		end
	endfunction

	assign start_msg = send_single_message_cmd_i || send_single_message_attn_cmd_i;
	assign start_any = recv_pad_cmd_i || start_msg;
	assign phase_ok  = is_msg_q ? (req_phase_i == PHASE_MSG_OUT) : (req_phase_i == PHASE_DATA_IN);

	// Sequencer: decide the termination and where it is reported.
	always_comb begin
		state_d = state_q;
		code_d  = code_q;
		step_d  = step_q;
		case (state_q)
			ST_IDLE: begin
				if (start_any) begin
					if (start_msg && (msg_len_i >= MSG_LEN_LIMIT)) begin
						code_d  = CODE_MSG_LONG;
						step_d  = STEP_DURING;
						state_d = ST_PUSH;
					end else begin
						state_d = ST_WREQ;
					end
				end
			end
			ST_WREQ: begin
				if (scsi_reset_i) begin
					code_d  = CODE_RESET;
					step_d  = STEP_BEFORE;
					state_d = ST_PUSH;
				end else if (bus_free_i && (is_msg_q || auto_recv_mode_i)) begin
					code_d  = CODE_FREE_FIRST;
					step_d  = STEP_BEFORE;
					state_d = ST_PUSH;
				end else if (bus_free_i) begin
					code_d  = CODE_BUS_FREE;
					step_d  = STEP_DURING;
					state_d = ST_EXIT;
				end else if (first_req_i) begin
					if (phase_ok) begin
						state_d = ST_XFER;
					end else if (auto_recv_mode_i && ((req_phase_i == PHASE_MSG_IN) ||
							(req_phase_i == PHASE_STATUS))) begin
						code_d  = unexp_code(req_phase_i == PHASE_STATUS,
							inbound_control_byte_buffer_full_i);
						step_d  = STEP_DURING;
						state_d = inbound_control_byte_buffer_full_i ? ST_PUSH : ST_UNEXP;
					end else begin
						code_d  = CODE_BAD_PHASE;
						step_d  = STEP_DURING;
						state_d = ST_PUSH;
					end
				end
			end
			ST_UNEXP: begin
				if (scsi_reset_i) begin
					code_d  = CODE_RESET;
					step_d  = STEP_DURING;
					state_d = ST_PUSH;
				end else if (unexp_byte_rcvd_i) begin
					code_d  = unexp_code(unexp_sts_q, 1'b0);
					step_d  = STEP_DURING;
					state_d = ST_PUSH;
				end
			end
			ST_XFER: begin
				if (scsi_reset_i) begin
					code_d  = CODE_RESET;
					step_d  = STEP_DURING;
					state_d = ST_PUSH;
				end else if (req_timeout_i && (is_msg_q || async_mode_i)) begin
					code_d  = CODE_TIMEOUT;
					step_d  = STEP_DURING;
					state_d = is_msg_q ? ST_PUSH : ST_EXIT;
				end else if (bus_free_i) begin
					code_d  = CODE_BUS_FREE;
					step_d  = STEP_DURING;
					state_d = is_msg_q ? ST_PUSH : ST_EXIT;
				end else if (phase_change_i) begin
					code_d  = CODE_PHASE_CHG;
					step_d  = STEP_DURING;
					state_d = is_msg_q ? ST_PUSH : ST_EXIT;
				end else if (pause_accept_i && !is_msg_q) begin
					code_d  = CODE_PAUSE;
					step_d  = STEP_DURING;
					state_d = ST_EXIT;
				end else if (xfer_done_i) begin
					code_d  = CODE_DONE;
					step_d  = done_step(auto_rst_ack_mode_i, padding_q || padding_active_i);
					state_d = ST_PUSH;
				end
			end
			ST_EXIT: begin
				if (exit_done_i) begin
					state_d = ST_PUSH;
				end
			end
			ST_PUSH: begin
				if (!q_full) begin
					state_d = par_err_q ? ST_PUSH2 : ST_IDLE;
				end
			end
			ST_PUSH2: begin
				if (!q_full) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= ST_IDLE;
			code_q  <= '0;
			step_q  <= '0;
		end else begin
			state_q <= state_d;
			code_q  <= code_d;
			step_q  <= step_d;
		end
	end

	// Command attributes held for the life of the command.
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			is_msg_q    <= 1'b0;
			keep_atn_q  <= 1'b0;
			unexp_sts_q <= 1'b0;
		end else if (state_q == ST_IDLE && start_any) begin
			is_msg_q    <= start_msg;
			keep_atn_q  <= send_single_message_attn_cmd_i;
			unexp_sts_q <= 1'b0;
		end else if (state_q == ST_WREQ && first_req_i) begin
			unexp_sts_q <= (req_phase_i == PHASE_STATUS);
		end
	end

	// Padding seen at any time in the transfer rules out the automatic step.
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			padding_q <= 1'b0;
		end else if (state_q == ST_IDLE) begin
			padding_q <= start_any && !start_msg && count_zero_i;
		end else if (padding_active_i) begin
			padding_q <= 1'b1;
		end
	end

	// A zero count starts padding at once; no interrupt is raised for it.
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pad_start_q <= 1'b0;
		end else begin
			pad_start_q <= (state_q == ST_IDLE) && recv_pad_cmd_i && !start_msg && count_zero_i;
		end
	end

	// ATN for message sends; kept on a wrong phase, dropped for an unexpected byte.
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			atn_q <= 1'b0;
		end else if (state_q == ST_IDLE && start_msg && (msg_len_i < MSG_LEN_LIMIT)) begin
			atn_q <= 1'b1;
		end else if (state_q == ST_WREQ && first_req_i && !phase_ok && auto_recv_mode_i &&
				((req_phase_i == PHASE_MSG_IN) || (req_phase_i == PHASE_STATUS))) begin
			atn_q <= 1'b0;
		end else if (state_q == ST_XFER && xfer_done_i && !keep_atn_q) begin
			atn_q <= 1'b0;
		end else if (scsi_reset_i || (bus_free_i && state_q != ST_IDLE)) begin
			atn_q <= 1'b0;
		end
	end

	// Register parity error: the set wins over the clear made by the report.
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			par_err_q <= 1'b0;
		end else if (reg_parity_err_i) begin
			par_err_q <= 1'b1;
		end else if (state_q == ST_PUSH2 && !q_full) begin
			par_err_q <= 1'b0;
		end
	end

	always_comb begin
		q_push    = 1'b0;
		q_wr_data = {code_q, step_q};
		if (state_q == ST_PUSH) begin
			q_push = !q_full;
		end else if (state_q == ST_PUSH2) begin
			q_push    = !q_full;
			q_wr_data = {CODE_REG_PARITY, STEP_BEFORE};
		end
	end

	assign q_pop = !int_pend_q && !pop_wait_q && !q_empty;

	code_queue #(
		.WIDTH (ENTRY_W),
		.DEPTH (QDEPTH)
	) u_queue (
		.sys_clk_i  (sys_clk_i),
		.rst_b_i    (rst_b_i),
		.push_i     (q_push),
		.wr_data_i  (q_wr_data),
		.full_o     (q_full),
		.pop_i      (q_pop),
		.empty_o    (q_empty),
		.rd_valid_o (q_rd_valid),
		.rd_data_o  (q_rd_data)
	);

	// Host view: one code pair at a time, held until acknowledged.
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pop_wait_q <= 1'b0;
			int_pend_q <= 1'b0;
			int_code_q <= '0;
			int_step_q <= '0;
		end else begin
			pop_wait_q <= q_pop;
			if (q_rd_valid) begin
				int_pend_q <= 1'b1;
				int_code_q <= q_rd_data[15:8];
				int_step_q <= q_rd_data[7:0];
			end else if (code_ack_i) begin
				int_pend_q <= 1'b0;
			end
		end
	end

	// Busy mirrors the sequencer so the host knows a command is running.
	logic busy_q;

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= (state_d != ST_IDLE);
		end
	end

	assign int_code_o       = int_code_q;
	assign int_step_o       = int_step_q;
	assign int_pend_o       = int_pend_q;
	assign busy_o           = busy_q;
	assign atn_o            = atn_q;
	assign pad_from_start_o = pad_start_q;

endmodule

`default_nettype wire

// >>> dv/initiator_int_codes_props.sv
`timescale 1ns/100ps
`default_nettype none

module initiator_int_codes_props
	import int_code_pkg::*;
#(
	parameter int QDEPTH = 4
) (
	// Clock and reset.
	input wire logic                 sys_clk_i,
	input wire logic                 rst_b_i,
	// Inputs of the block.
	input wire logic                 send_single_message_cmd_i,
	input wire logic [MSG_LEN_W-1:0] msg_len_i,
	input wire logic                 auto_recv_mode_i,
	input wire logic                 auto_rst_ack_mode_i,
	input wire logic                 scsi_reset_i,
	input wire logic                 bus_free_i,
	input wire logic                 first_req_i,
	input wire logic [2:0]           req_phase_i,
	input wire logic                 padding_active_i,
	input wire logic                 xfer_done_i,
	input wire logic                 code_ack_i,
	// Outputs of the block.
	input wire logic [7:0]           int_code_o,
	input wire logic [7:0]           int_step_o,
	input wire logic                 int_pend_o,
	input wire logic                 busy_o,
	input wire logic                 atn_o
);
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	logic seen_req_q;
	logic odd_phase;

	assign odd_phase = req_phase_i == PHASE_MSG_IN || req_phase_i == PHASE_STATUS;

	// Marks that the running command has already seen its first REQ.
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			seen_req_q <= 1'b0;
		else if (!busy_o)
			seen_req_q <= 1'b0;
		else if (first_req_i)
			seen_req_q <= 1'b1;
	end

	chk_pend_holds: assert property (int_pend_o && !code_ack_i
		|=> int_pend_o && $stable(int_code_o) && $stable(int_step_o))
		else $error("code pair changed while pending");
	chk_ack_release: assert property (int_pend_o && code_ack_i |=> !int_pend_o)
		else $error("pending flag kept after host read");
	chk_no_count_code: assert property (int_pend_o |-> int_code_o != 8'h65)
		else $error("zero count condition was reported");
	chk_pad_step: assert property (busy_o && xfer_done_i && padding_active_i
		|-> ##4 int_pend_o && int_step_o != STEP_DONE_AUTO)
		else $error("automatic step used during padding");
	chk_msg_long: assert property (send_single_message_cmd_i && !busy_o && msg_len_i >= MSG_LEN_LIMIT
		|-> ##[2:5] (int_pend_o && int_code_o == CODE_MSG_LONG && int_step_o == STEP_DURING))
		else $error("long message not refused");
	chk_reset_code: assert property (busy_o && scsi_reset_i |-> ##4 int_pend_o && int_code_o == CODE_RESET)
		else $error("reset not reported");
	chk_atn_kept: assert property (busy_o && atn_o && first_req_i && !auto_recv_mode_i
		&& req_phase_i != PHASE_MSG_OUT |=> atn_o [*4])
		else $error("attention dropped on wrong phase");
	chk_atn_drop: assert property (busy_o && atn_o && first_req_i && auto_recv_mode_i && odd_phase
		|-> ##[1:12] !atn_o)
		else $error("attention kept on unexpected byte");
	chk_bad_phase: assert property (busy_o && !atn_o && first_req_i && !auto_recv_mode_i
		&& req_phase_i != PHASE_DATA_IN && !seen_req_q
		|-> ##4 int_pend_o && int_code_o == CODE_BAD_PHASE && int_step_o == STEP_DURING)
		else $error("wrong receive phase not reported");
	chk_free_first: assert property (busy_o && !seen_req_q && bus_free_i && !scsi_reset_i
		&& (atn_o || auto_recv_mode_i)
		|-> ##4 int_pend_o && int_code_o == CODE_FREE_FIRST && int_step_o == STEP_BEFORE)
		else $error("early bus free not reported");
	chk_done_code: assert property (busy_o && seen_req_q && xfer_done_i && !auto_rst_ack_mode_i
		&& !scsi_reset_i && !bus_free_i
		|-> ##4 int_pend_o && int_code_o == CODE_DONE && int_step_o == STEP_DONE_MAN)
		else $error("normal end not reported");

	cover property (int_pend_o && int_code_o == CODE_REG_PARITY);
	cover property (int_pend_o && int_step_o == STEP_DONE_AUTO);
	cover property (int_pend_o && int_code_o == CODE_BUSY_STS);
endmodule

bind initiator_int_codes initiator_int_codes_props #(.QDEPTH(QDEPTH)) i_props (
	.sys_clk_i, .rst_b_i, .send_single_message_cmd_i, .msg_len_i, .auto_recv_mode_i, .auto_rst_ack_mode_i,
	.scsi_reset_i, .bus_free_i, .first_req_i, .req_phase_i, .padding_active_i, .xfer_done_i, .code_ack_i,
	.int_code_o, .int_step_o, .int_pend_o, .busy_o, .atn_o
);

`default_nettype wire

// >>> dv/scsi_target_model.sv
`timescale 1ns/100ps
`default_nettype none

module scsi_target_model (
	// Clock and script from the bench.
	input  wire logic       sys_clk_i,
	input  wire logic       go_i,
	input  wire logic [3:0] ev_i,
	input  wire logic [2:0] phase_i,
	// Bus events towards the block.
	output logic            scsi_reset_o,
	output logic            bus_free_o,
	output logic            req_timeout_o,
	output logic            phase_change_o,
	output logic            pause_accept_o,
	output logic            first_req_o,
	output logic [2:0]      req_phase_o,
	output logic            unexp_byte_o,
	output logic            xfer_done_o,
	output logic            exit_done_o
);
	logic [8:0] line_q = 9'h000;
	logic [2:0] junk_q = 3'h0;

	assign {exit_done_o, xfer_done_o, unexp_byte_o, first_req_o, pause_accept_o,
		phase_change_o, req_timeout_o, bus_free_o, scsi_reset_o} = line_q;
	// The phase lines mean nothing outside the first REQ, so they keep moving there.
	assign req_phase_o = first_req_o ? phase_i : junk_q;

	always @(posedge sys_clk_i)
		junk_q <= junk_q + 3'h5;

	task automatic fire(input int idx);
		line_q <= 9'h001 << idx;
		@(posedge sys_clk_i);
		line_q <= 9'h000;
	endtask

	// One command: the first REQ unless the event is early, the event, then exit processing.
	initial begin
		forever begin
			@(posedge sys_clk_i);
			if (go_i) begin
				@(posedge sys_clk_i);
				if (!ev_i[3]) begin
					fire(5);
					@(posedge sys_clk_i);
				end
				fire(int'(ev_i[2:0]));
				repeat (2) @(posedge sys_clk_i);
				fire(8);
			end
		end
	end
endmodule

`default_nettype wire

// >>> dv/scsi_initiator_int_codes_test.sv
`timescale 1ns/100ps
`default_nettype none

module scsi_initiator_int_codes_test;
	import int_code_pkg::*;

	logic       sys_clk_i, rst_b_i, recv_pad_cmd_i, send_single_message_cmd_i, send_single_message_attn_cmd_i;
	logic       count_zero_i, auto_recv_mode_i, auto_rst_ack_mode_i, async_mode_i, scsi_reset_i, bus_free_i;
	logic       req_timeout_i, phase_change_i, pause_accept_i, first_req_i, unexp_byte_rcvd_i, padding_active_i;
	logic       inbound_control_byte_buffer_full_i, xfer_done_i, exit_done_i, reg_parity_err_i, code_ack_i;
	logic       int_pend_o, busy_o, atn_o, pad_from_start_o, go;
	logic [7:0] msg_len_i, int_code_o, int_step_o;
	logic [2:0] req_phase_i, phase;
	logic [3:0] ev;
	int         bad_count = 0;
	int         n_tests = 0;
	int         pad_n = 0;
	int         cyc = 0;

	initiator_int_codes #(
		.QDEPTH(4)
	) i_dut (
		.sys_clk_i, .rst_b_i, .recv_pad_cmd_i, .send_single_message_cmd_i, .send_single_message_attn_cmd_i,
		.msg_len_i, .count_zero_i, .auto_recv_mode_i, .auto_rst_ack_mode_i, .async_mode_i, .scsi_reset_i,
		.bus_free_i, .req_timeout_i, .phase_change_i, .pause_accept_i, .first_req_i, .req_phase_i,
		.unexp_byte_rcvd_i, .inbound_control_byte_buffer_full_i, .padding_active_i, .xfer_done_i,
		.exit_done_i, .reg_parity_err_i, .code_ack_i, .int_code_o, .int_step_o, .int_pend_o, .busy_o,
		.atn_o, .pad_from_start_o
	);

	scsi_target_model i_target (
		.sys_clk_i(sys_clk_i), .go_i(go), .ev_i(ev), .phase_i(phase), .scsi_reset_o(scsi_reset_i),
		.bus_free_o(bus_free_i), .req_timeout_o(req_timeout_i), .phase_change_o(phase_change_i),
		.pause_accept_o(pause_accept_i), .first_req_o(first_req_i), .req_phase_o(req_phase_i),
		.unexp_byte_o(unexp_byte_rcvd_i), .xfer_done_o(xfer_done_i), .exit_done_o(exit_done_i)
	);

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	always @(negedge sys_clk_i)
		if (pad_from_start_o === 1'b1)
			pad_n++;

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic get_pair(input logic [7:0] code, input logic [7:0] step, input logic [3:0] atn);
		int n;
		n = 0;
		while (int_pend_o !== 1'b1 && n < 40) begin
			@(negedge sys_clk_i);
			n++;
		end
		check({7'h00, int_pend_o}, 8'h01);
		check(int_code_o, code);
		check(int_step_o, step);
		if (atn < 4'h2)
			check({7'h00, atn_o}, {4'h0, atn});
		@(posedge sys_clk_i);
		code_ack_i <= 1'b1;
		@(posedge sys_clk_i);
		code_ack_i <= 1'b0;
		repeat (2) @(negedge sys_clk_i);
		check({7'h00, int_pend_o}, 8'h00);
		check({7'h00, busy_o}, 8'h00);
	endtask

	// Row fields: command, event, phase, flags {parity, zero count, full, padding, auto ack, auto recv},
	// length, code, step, ATN expected (2 means not looked at).
	task automatic run(input logic [47:0] r);
		@(posedge sys_clk_i);
		{count_zero_i, inbound_control_byte_buffer_full_i, padding_active_i, auto_rst_ack_mode_i,
			auto_recv_mode_i} <= r[32:28];
		ev <= r[43:40];
		phase <= r[38:36];
		msg_len_i <= r[27:20];
		pad_n = 0;
		@(posedge sys_clk_i);
		recv_pad_cmd_i <= (r[47:44] == 4'h0);
		send_single_message_cmd_i <= (r[47:44] == 4'h1);
		send_single_message_attn_cmd_i <= (r[47:44] == 4'h2);
		reg_parity_err_i <= r[33];
		go <= 1'b1;
		@(posedge sys_clk_i);
		{recv_pad_cmd_i, send_single_message_cmd_i, send_single_message_attn_cmd_i, reg_parity_err_i, go} <= 5'h00;
		get_pair(r[19:12], r[11:4], r[3:0]);
		if (r[33])
			get_pair(CODE_REG_PARITY, STEP_BEFORE, 4'h2);
		check(pad_n[7:0], {7'h00, r[32]});
		repeat (10) @(posedge sys_clk_i);
	endtask

	initial begin
		{rst_b_i, recv_pad_cmd_i, send_single_message_cmd_i, send_single_message_attn_cmd_i, count_zero_i,
			auto_recv_mode_i, auto_rst_ack_mode_i, inbound_control_byte_buffer_full_i, padding_active_i,
			reg_parity_err_i, code_ack_i, go} = 12'h000;
		{msg_len_i, ev, phase} = 15'h0000;
		async_mode_i = 1'b1;
		repeat (16) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		check({4'h0, int_pend_o, busy_o, atn_o, pad_from_start_o}, 8'h00);
		@(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		// Phases: 1 data-in, 3 status, 6 message-out, 7 message-in.
		run(48'h1_7_6_00_04_60_02_0);
		run(48'h1_7_6_02_20_60_0a_0);
		run(48'h0_7_1_00_04_60_02_0);
		run(48'h0_7_1_02_04_60_0a_0);
		run(48'h0_7_1_06_04_60_02_0);
		run(48'h0_7_1_12_04_60_02_0);
		run(48'h0_2_1_00_04_2c_01_0);
		run(48'h0_1_1_00_04_31_01_0);
		run(48'h0_3_1_00_04_32_01_0);
		run(48'h0_4_1_00_04_67_01_0);
		run(48'h0_6_7_00_04_54_01_0);
		run(48'h0_6_7_01_04_55_01_0);
		run(48'h0_6_3_01_04_56_01_0);
		run(48'h0_6_7_09_04_5d_01_0);
		run(48'h0_6_3_09_04_5e_01_0);
		run(48'h0_9_1_01_04_70_00_0);
		run(48'h0_9_1_00_04_31_01_0);
		run(48'h1_8_6_00_04_01_00_0);
		run(48'h1_0_6_00_04_01_01_0);
		run(48'h1_2_6_00_04_2c_01_2);
		run(48'h1_1_6_00_04_31_01_0);
		run(48'h1_3_6_00_04_32_01_2);
		run(48'h1_9_6_00_04_70_00_0);
		run(48'h1_6_7_01_04_55_01_0);
		run(48'h1_6_3_09_04_5e_01_0);
		run(48'h1_7_6_20_04_60_02_0);
		run(48'h0_7_1_20_04_60_02_0);
		run(48'h1_7_6_00_21_64_01_2);
		run(48'h2_7_6_00_04_60_02_1);
		run(48'h1_6_7_00_04_54_01_1);
		conclude();
	end
endmodule

`default_nettype wire
